// >>> design/lcdr_loader.v
/*
  display data path of a segment lcd driver: control byte parser, command
  decoder, data pointer, two-bank ram loading, register slave.
  assumes the serial front end delivers whole bytes on core_clk_in with a
  one-cycle start pulse per access, and an avalon-mm master.
*/
// Added by the designer: the register addresses and register access over Avalon-MM.
// Contract
// - four-backplane mode: each backplane output has its own waveform.
// - two-backplane mode: third copies first, fourth copies second backplane.
// - static mode: all four backplane outputs carry the first backplane.
// - 44 segment outputs from backplane timing and display register bits.
// - ram is 44 columns by 4, 2 or 1 rows per bank, two banks.
// - ram bit one turns element on, zero leaves it off.
// - four rows map to backplanes per bank; columns map to segments.
// - after pointer load, next display byte stores at the pointer.
// - pointer steps eight, four or two columns per stored byte.
// - pointer stops at row end; excess bits and bytes are discarded.
// - static: byte fills eight columns of one row; six bytes per row.
// - two-backplane: byte fills four columns over two rows; 11 bytes.
// - four-backplane: byte fills two columns over four rows; 22 bytes.
// - input bank one writes rows from 4 upward.
// - input bank bit alone chooses the written bank.
// - output bank bit alone chooses the displayed bank.
// - display register holds active bank data stable during its frame.
// - control byte follows address; bit 7 set means more control bytes.
// - bit 6 routes bytes to commands or ram; bits 5..0 ignored.
// - an access carries commands, ram bytes, or a mixture.
// - multiplex mode is set by the multiplex set command.
`timescale 1ns/1ps
`default_nettype none
`include "lcdr_defines.vh"
module lcdr_loader (
  input  wire        core_clk_in,
  input  wire        nrst_in,
  input  wire        frame_start_in,
  input  wire        rx_valid_in,
  input  wire [7:0]  rx_byte_in,
  input  wire [3:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  output wire        backplane_out_a,
  output wire        backplane_out_b,
  output wire        backplane_out_c,
  output wire        backplane_out_d,
  output wire [43:0] segment_out
);
  localparam [1:0] ST_CTRL   = 2'd0;
  localparam [1:0] ST_ONE    = 2'd1;
  localparam [1:0] ST_STREAM = 2'd2;

  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg         kind_r;
  reg         kind_nxt;
  reg  [1:0]  mode_r;
  reg  [1:0]  mode_nxt;
  reg         write_bank_sel_r;
  reg         write_bank_sel_nxt;
  reg         show_bank_sel_r;
  reg         show_bank_sel_nxt;
  reg  [5:0]  ptr_r;
  reg  [5:0]  ptr_nxt;
  reg  [7:0]  ram_cnt_r;
  reg  [7:0]  drop_cnt_r;
  reg  [7:0]  cmd_cnt_r;
  reg  [31:0] rd_mux;

  wire [7:0]   lane_we;
  wire [47:0]  lane_col;
  wire [23:0]  lane_row;
  wire [7:0]   lane_bit;
  wire [351:0] ram_data;

  // byte classification
  wire at_ctrl   = frame_start_in || (state_r == ST_CTRL);
  wire ctrl_byte = rx_valid_in && at_ctrl;
  wire data_byte = rx_valid_in && !at_ctrl;
  wire row_end   = (ptr_r >= `LCDR_COLS);
  wire take_ram  = data_byte && kind_r && !row_end;
  wire drop_ram  = data_byte && kind_r && row_end;
  wire take_cmd  = data_byte && !kind_r;

  wire is_static = (mode_r == `LCDR_MODE_STATIC);
  wire is_mux2   = (mode_r == `LCDR_MODE_MUX2);

  // command decode
  wire cmd_ptr  = take_cmd && (rx_byte_in[7:6] == `LCDR_CMD_PTR_TAG);
  wire cmd_mode = take_cmd && (rx_byte_in[7:2] == `LCDR_CMD_MODE_TAG) &&
                  (rx_byte_in[1:0] != 2'b11);
  wire cmd_bank = take_cmd && (rx_byte_in[7:2] == `LCDR_CMD_BANK_TAG);

  // register slave handshake: one wait cycle, answer on the second edge
  wire bus_req  = (avs_read_in || avs_write_in) && avs_waitrequest_out;
  wire bus_wr   = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  wire wr_cfg   = bus_wr && (avs_address_in == `LCDR_REG_CONFIG);
  wire wr_ptr   = bus_wr && (avs_address_in == `LCDR_REG_POINTER);
  wire wr_cnt   = bus_wr && (avs_address_in == `LCDR_REG_COUNT);

  // pointer step per multiplex mode
  wire [6:0] step = is_static ? `LCDR_STEP_STATIC :
                    is_mux2 ? `LCDR_STEP_MUX2 : `LCDR_STEP_MUX4;
  wire [6:0] ptr_sum = {1'b0, ptr_r} + step;

  // one lane per received bit, msb first into the lowest column
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : lane
      localparam integer GI    = g;
      localparam [5:0]   OFF_S = GI[5:0];
      localparam [5:0]   OFF_2 = GI[6:1];
      localparam [5:0]   OFF_4 = GI[7:2];
      localparam [1:0]   ROW_2 = {1'b0, GI[0]};
      localparam [1:0]   ROW_4 = GI[1:0];
      wire [5:0] col = ptr_r + (is_static ? OFF_S : is_mux2 ? OFF_2 : OFF_4);
      wire [1:0] sub = is_static ? 2'd0 : is_mux2 ? ROW_2 : ROW_4;
      assign lane_col[g*6 +: 6] = col;
      assign lane_row[g*3 +: 3] = {write_bank_sel_r, sub};
      assign lane_bit[g]        = rx_byte_in[7-g];
      assign lane_we[g]         = take_ram && (col < `LCDR_COLS);
    end
  endgenerate

  // parser
  always @* begin
    state_nxt = state_r;
    kind_nxt  = kind_r;
    if (frame_start_in && !rx_valid_in) begin
      state_nxt = ST_CTRL;
    end else if (ctrl_byte) begin
      kind_nxt  = rx_byte_in[`LCDR_CTRL_KIND_BIT];
      state_nxt = rx_byte_in[`LCDR_CTRL_MORE_BIT] ? ST_ONE : ST_STREAM;
    end else if (data_byte && (state_r == ST_ONE)) begin
      state_nxt = ST_CTRL;
    end
  end

  // settings: a stream command beats a bus write in the same cycle
  always @* begin
    mode_nxt           = mode_r;
    write_bank_sel_nxt = write_bank_sel_r;
    show_bank_sel_nxt  = show_bank_sel_r;
    ptr_nxt            = ptr_r;
    if (wr_cfg) begin
      if (avs_writedata_in[1:0] != 2'b11) begin
        mode_nxt = avs_writedata_in[1:0];
      end
      write_bank_sel_nxt = avs_writedata_in[`LCDR_CFG_IBS_BIT];
      show_bank_sel_nxt  = avs_writedata_in[`LCDR_CFG_OBS_BIT];
    end
    if (wr_ptr) begin
      ptr_nxt = avs_writedata_in[5:0];
    end
    if (cmd_mode) begin
      mode_nxt = rx_byte_in[1:0];
    end
    if (cmd_bank) begin
      write_bank_sel_nxt = rx_byte_in[1];
      show_bank_sel_nxt  = rx_byte_in[0];
    end
    if (cmd_ptr) begin
      ptr_nxt = rx_byte_in[5:0];
    end
    if (take_ram) begin
      if (ptr_sum >= {1'b0, `LCDR_COLS}) begin
        ptr_nxt = `LCDR_COLS;
      end else begin
        ptr_nxt = ptr_sum[5:0];
      end
    end
  end

  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r          <= ST_CTRL;
      kind_r           <= 1'b0;
      mode_r           <= `LCDR_MODE_RST;
      write_bank_sel_r <= 1'b0;
      show_bank_sel_r  <= 1'b0;
      ptr_r            <= 6'd0;
    end else begin
      state_r          <= state_nxt;
      kind_r           <= kind_nxt;
      mode_r           <= mode_nxt;
      write_bank_sel_r <= write_bank_sel_nxt;
      show_bank_sel_r  <= show_bank_sel_nxt;
      ptr_r            <= ptr_nxt;
    end
  end

  // activity counters; an event in the clearing cycle still counts
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ram_cnt_r  <= 8'h00;
      drop_cnt_r <= 8'h00;
      cmd_cnt_r  <= 8'h00;
    end else begin
      ram_cnt_r  <= (wr_cnt ? 8'h00 : ram_cnt_r) + {7'h00, take_ram};
      drop_cnt_r <= (wr_cnt ? 8'h00 : drop_cnt_r) + {7'h00, drop_ram};
      cmd_cnt_r  <= (wr_cnt ? 8'h00 : cmd_cnt_r) + {7'h00, take_cmd};
    end
  end

  // read mux; unmapped and unaligned addresses read zero
  always @* begin
    case (avs_address_in)
      `LCDR_REG_CONFIG: begin
        rd_mux = {28'h0000000, show_bank_sel_r, write_bank_sel_r, mode_r};
      end
      `LCDR_REG_POINTER: begin
        rd_mux = {26'h0000000, ptr_r};
      end
      `LCDR_REG_STATUS: begin
        rd_mux = {26'h0000000, write_bank_sel_r, show_bank_sel_r, kind_r, state_r, row_end};
      end
      `LCDR_REG_COUNT: begin
        rd_mux = {8'h00, cmd_cnt_r, drop_cnt_r, ram_cnt_r};
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h00000000;
    end else begin
      avs_waitrequest_out <= !bus_req;
      if (bus_req && avs_read_in) begin
        avs_readdata_out <= rd_mux;
      end
    end
  end

  lcdr_disp_ram u_ram (
    .clk_in       (core_clk_in),
    .nrst_in      (nrst_in),
    .lane_we_in   (lane_we),
    .lane_col_in  (lane_col),
    .lane_row_in  (lane_row),
    .lane_bit_in  (lane_bit),
    .ram_data_out (ram_data)
  );

  lcdr_waveform u_wave (
    .clk_in       (core_clk_in),
    .nrst_in      (nrst_in),
    .mode_in      (mode_r),
    .show_bank_in (show_bank_sel_r),
    .ram_data_in  (ram_data),
    .bp_a_out     (backplane_out_a),
    .bp_b_out     (backplane_out_b),
    .bp_c_out     (backplane_out_c),
    .bp_d_out     (backplane_out_d),
    .seg_out      (segment_out)
  );
endmodule
`default_nettype wire

// >>> common/lcdr_defines.vh
/*
  constants of the display ram loader: geometry, mode codes, command
  codes, control byte fields, register map and display timing.
  assumes inclusion by bare name from the design files.
*/
`ifndef LCDR_DEFINES_VH
`define LCDR_DEFINES_VH

`define LCDR_COLS          6'd44
`define LCDR_MODE_MUX4     2'b00
`define LCDR_MODE_STATIC   2'b01
`define LCDR_MODE_MUX2     2'b10
`define LCDR_MODE_RST      2'b00
`define LCDR_STEP_STATIC   7'd8
`define LCDR_STEP_MUX2     7'd4
`define LCDR_STEP_MUX4     7'd2

`define LCDR_CTRL_MORE_BIT 7
`define LCDR_CTRL_KIND_BIT 6

`define LCDR_CMD_PTR_TAG   2'b00
`define LCDR_CMD_MODE_TAG  6'h30
`define LCDR_CMD_BANK_TAG  6'h3E

`define LCDR_REG_CONFIG    4'h0
`define LCDR_REG_POINTER   4'h4
`define LCDR_REG_STATUS    4'h8
`define LCDR_REG_COUNT     4'hC
`define LCDR_CFG_IBS_BIT   2
`define LCDR_CFG_OBS_BIT   3

`define LCDR_CLK_MHZ       50
`define LCDR_PHASE_US      20
`define LCDR_PHASE_CYCLES  (`LCDR_PHASE_US * `LCDR_CLK_MHZ)

`endif

// >>> design/lcdr_disp_ram.v
/*
  two-bank display ram, 44 columns by 8 rows, eight write lanes per clock.
  assumes lane columns and rows come from the loader on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module lcdr_disp_ram (
  input  wire         clk_in,
  input  wire         nrst_in,
  input  wire [7:0]   lane_we_in,
  input  wire [47:0]  lane_col_in,
  input  wire [23:0]  lane_row_in,
  input  wire [7:0]   lane_bit_in,
  output wire [351:0] ram_data_out
);
  genvar c;
  generate
    for (c = 0; c < 44; c = c + 1) begin : col
      localparam integer CI  = c;
      localparam [5:0]   COL = CI[5:0];
      reg [7:0] cell_r;
      reg [7:0] cell_nxt;
      integer   i;
      always @* begin
        cell_nxt = cell_r;
        for (i = 0; i < 8; i = i + 1) begin
          if (lane_we_in[i] && (lane_col_in[i*6 +: 6] == COL)) begin
            cell_nxt[lane_row_in[i*3 +: 3]] = lane_bit_in[i];
          end
        end
      end
      always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          cell_r <= 8'h00;
        end else begin
          cell_r <= cell_nxt;
        end
      end
      assign ram_data_out[c*8 +: 8] = cell_r;
    end
  endgenerate
endmodule
`default_nettype wire

// >>> design/lcdr_waveform.v
/*
  display register and digital backplane / segment phase generator.
  assumes ram contents and bank/mode settings on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lcdr_defines.vh"
module lcdr_waveform (
  input  wire         clk_in,
  input  wire         nrst_in,
  input  wire [1:0]   mode_in,
  input  wire         show_bank_in,
  input  wire [351:0] ram_data_in,
  output reg          bp_a_out,
  output reg          bp_b_out,
  output reg          bp_c_out,
  output reg          bp_d_out,
  output reg  [43:0]  seg_out
);
  localparam integer DWELL_N    = `LCDR_PHASE_CYCLES - 1;
  localparam [9:0]   DWELL_LAST = DWELL_N[9:0];
  reg  [9:0]   dwell_r;
  reg  [1:0]   phase_r;
  reg          inv_r;
  reg  [175:0] disp_r;
  wire [1:0]   last_phase = (mode_in == `LCDR_MODE_STATIC) ? 2'd0 :
                            (mode_in == `LCDR_MODE_MUX2) ? 2'd1 : 2'd3;
  wire         dwell_end = (dwell_r == DWELL_LAST);
  wire         frame_end = dwell_end && (phase_r >= last_phase);
  wire         sel0 = (phase_r == 2'd0) ^ inv_r;
  wire         sel1 = (phase_r == 2'd1) ^ inv_r;
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dwell_r <= 10'h000;
      phase_r <= 2'd0;
      inv_r   <= 1'b0;
    end else begin
      dwell_r <= dwell_end ? 10'h000 : dwell_r + 10'h001;
      if (frame_end) begin
        phase_r <= 2'd0;
        inv_r   <= ~inv_r;
      end else if (dwell_end) begin
        phase_r <= phase_r + 2'd1;
      end
    end
  end
  // backplane mapping per multiplex mode
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bp_a_out <= 1'b0;
      bp_b_out <= 1'b0;
      bp_c_out <= 1'b0;
      bp_d_out <= 1'b0;
    end else begin
      bp_a_out <= sel0;
      bp_b_out <= (mode_in == `LCDR_MODE_STATIC) ? sel0 : sel1;
      if (mode_in == `LCDR_MODE_MUX4) begin
        bp_c_out <= (phase_r == 2'd2) ^ inv_r;
        bp_d_out <= (phase_r == 2'd3) ^ inv_r;
      end else begin
        bp_c_out <= sel0;
        bp_d_out <= (mode_in == `LCDR_MODE_MUX2) ? sel1 : sel0;
      end
    end
  end
  genvar c;
  generate
    for (c = 0; c < 44; c = c + 1) begin : seg
      // latched only at frame end, so a bank swap never tears a frame
      always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          disp_r[c*4 +: 4] <= 4'h0;
          seg_out[c]       <= 1'b0;
        end else begin
          if (frame_end) begin
            disp_r[c*4 +: 4] <= ram_data_in[c*8 + {show_bank_in, 2'b00} +: 4];
          end
          seg_out[c] <= (~disp_r[c*4 + phase_r]) ^ inv_r;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// >>> verification/lcdr_loader_props.sv
/* checker of the loader ports: bus handshake, backplane mapping, display hold.
   assumes a bind to lcdr_loader on one clock; mode is trusted only after a
   settled register write with no byte traffic since. */
`timescale 1ns/1ps
`default_nettype none
`include "lcdr_defines.vh"
module lcdr_loader_props (
  input wire logic        core_clk_in,
  input wire logic        nrst_in,
  input wire logic        rx_valid_in,
  input wire logic [3:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        backplane_out_a,
  input wire logic        backplane_out_b,
  input wire logic        backplane_out_c,
  input wire logic        backplane_out_d,
  input wire logic [43:0] segment_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  logic [1:0] mode_r;
  logic [1:0] age_r;
  logic       known_r;
  wire        cfg_wr = avs_write_in && !avs_waitrequest_out && avs_address_in == 4'h0 && avs_byteenable_in[0];
  wire        ok = known_r && age_r == 2'h3;
  wire [3:0]  bp = {backplane_out_d, backplane_out_c, backplane_out_b, backplane_out_a};
  logic [43:0] seg_q;
  logic [9:0]  quiet_r;
  // two-backplane frame end may leave every backplane level as it was,
  // so segment moves are judged by their spacing, one dwell at least
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      seg_q   <= 44'h0;
      quiet_r <= 10'h000;
    end else begin
      seg_q <= segment_out;
      if (segment_out != seg_q) begin
        quiet_r <= 10'h000;
      end else if (quiet_r != 10'h3FF) begin
        quiet_r <= quiet_r + 10'h001;
      end
    end
  end
  // stream commands may change the mode unseen, so byte traffic spoils it
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_r  <= 2'h0;
      age_r   <= 2'h0;
      known_r <= 1'b0;
    end else if (cfg_wr) begin
      mode_r  <= avs_writedata_in[1:0];
      age_r   <= 2'h0;
      known_r <= 1'b1;
    end else if (rx_valid_in) begin
      known_r <= 1'b0;
    end else if (age_r != 2'h3) begin
      age_r <= age_r + 2'h1;
    end
  end
  a_answer_one_wait: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("request not answered after one wait cycle");
  a_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  a_no_idle_answer: assert property (!(avs_read_in || avs_write_in) && avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer without a request");
  a_unmapped_zero: assert property (avs_read_in && avs_waitrequest_out && avs_address_in[1:0] != 2'h0
    |=> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
  a_mux4_distinct: assert property (ok && mode_r == 2'h0 |-> $onehot(bp) || $onehot(~bp))
    else $error("four backplanes not distinct");
  a_mux2_copy: assert property (ok && mode_r == 2'h2 |-> bp[2] == bp[0] && bp[3] == bp[1])
    else $error("two backplane copy wrong");
  a_static_copy: assert property (ok && mode_r == 2'h1 |-> bp == {4{bp[0]}})
    else $error("static backplanes differ");
  a_seg_steady: assert property (ok && segment_out != seg_q |-> quiet_r >= `LCDR_PHASE_CYCLES - 1)
    else $error("segments moved inside a phase");
  cover property (ok && mode_r == 2'h1);
  cover property (ok && mode_r == 2'h2);
  cover property (avs_read_in && !avs_waitrequest_out);
endmodule
bind lcdr_loader lcdr_loader_props i_props (.core_clk_in, .nrst_in, .rx_valid_in, .avs_address_in, .avs_read_in,
  .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
  .backplane_out_a, .backplane_out_b, .backplane_out_c, .backplane_out_d, .segment_out);
`default_nettype wire

// >>> verification/lcdr_host_model.sv
/* host side of the byte stream: control bytes, commands, ram bursts.
   assumes callers start tasks between bus cycles of the bench. */
`timescale 1ns/1ps
`default_nettype none
module lcdr_host_model (
  input  wire logic       core_clk_in,
  output var  logic       frame_start_out,
  output var  logic       rx_valid_out,
  output var  logic [7:0] rx_byte_out
);
  initial begin
    frame_start_out = 1'b0;
    rx_valid_out    = 1'b0;
    rx_byte_out     = 8'h00;
  end
  // calls back to back give an unbroken burst
  task put(input logic first, input logic [7:0] b);
    @(posedge core_clk_in);
    frame_start_out <= first;
    rx_valid_out    <= 1'b1;
    rx_byte_out     <= b;
  endtask
  // released lane shows the inverse, never a stale byte
  task idle;
    @(posedge core_clk_in);
    frame_start_out <= 1'b0;
    rx_valid_out    <= 1'b0;
    rx_byte_out     <= ~rx_byte_out;
  endtask
  // low control bits set on purpose; every burst reloads the pointer first
  task ram_at(input logic [5:0] p, input int cnt, input logic [7:0] b);
    put(1'b1, 8'hBF);
    put(1'b0, {2'b00, p});
    put(1'b0, 8'h7F);
    repeat (cnt) put(1'b0, b);
    idle;
  endtask
  task cmd(input logic [7:0] c);
    put(1'b1, 8'h3F);
    put(1'b0, c);
    idle;
  endtask
endmodule
`default_nettype wire

// >>> verification/lcdr_loader_test.sv
/* bench of the loader: avalon master tasks, host bytes, self checks.
   assumes the host model owns the byte stream inputs. */
`timescale 1ns/1ps
`default_nettype none
module lcdr_loader_test;
  logic        clk;
  logic        nrst;
  logic        rd;
  logic        wr;
  logic [3:0]  adr;
  logic [31:0] wd;
  logic [31:0] q;
  logic [3:0]  be;
  logic [1:0]  md;
  wire logic        frm;
  wire logic        vld;
  wire logic [7:0]  rxb;
  wire logic [31:0] rdq;
  wire logic        wt;
  wire logic [43:0] seg;
  wire logic        bpa;
  wire logic        bpb;
  wire logic        bpc;
  wire logic        bpd;
  int errors;
  int samples_checked;
  int n;
  int m;
  int st;
  int nb;
  int k;
  lcdr_host_model i_host (.core_clk_in(clk), .frame_start_out(frm), .rx_valid_out(vld), .rx_byte_out(rxb));
  lcdr_loader i_dut (.core_clk_in(clk), .nrst_in(nrst), .frame_start_in(frm), .rx_valid_in(vld),
    .rx_byte_in(rxb), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_byteenable_in(be), .avs_readdata_out(rdq), .avs_waitrequest_out(wt), .backplane_out_a(bpa),
    .backplane_out_b(bpb), .backplane_out_c(bpc), .backplane_out_d(bpd), .segment_out(seg));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task conclude;
    $display("compares %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // entered just after a rising edge; answer time is not assumed
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    rd  <= ~w;
    wr  <= w;
    adr <= a;
    wd  <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wt !== 1'b0 && n < 50);
    if (wt !== 1'b0) begin
      errors++;
      conclude;
    end
    q = rdq;
    rd <= 1'b0;
    wr <= 1'b0;
    // one idle edge so a following call never re-raises a strobe in this step
    @(posedge clk);
  endtask
  task rchk(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(q & mask, exp);
  endtask
  task frames(input int c);
    repeat (c) @(posedge clk);
  endtask
  initial begin
    nrst = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 4'h0;
    wd = 32'h0;
    be = 4'hF;
    errors = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rchk(4'h4, 32'h3F, 32'h0);
    rchk(4'h0, 32'hF, 32'h0);
    rchk(4'h8, 32'h31, 32'h0);
    rchk(4'h2, 32'hFFFFFFFF, 32'h0);
    be <= 4'hE;
    bus(1'b1, 4'h4, 32'h15);
    be <= 4'hF;
    rchk(4'h4, 32'h3F, 32'h0);
    $display("test 1 done");
    for (m = 0; m < 3; m++) begin
      md = (m == 0) ? 2'h1 : (m == 1) ? 2'h2 : 2'h0;
      st = (m == 0) ? 8 : (m == 1) ? 4 : 2;
      nb = (m == 0) ? 6 : (m == 1) ? 11 : 22;
      k = (m == 2) ? 2 : 1;
      i_host.cmd(8'hC0 | md);
      rchk(4'h0, 32'h3, md);
      i_host.cmd(8'hC3);
      rchk(4'h0, 32'h3, md);
      i_host.ram_at(6'd3, 2, 8'h5A);
      rchk(4'h4, 32'h3F, 3 + 2 * st);
      bus(1'b1, 4'hC, 32'h0);
      i_host.ram_at(6'd0, nb, 8'h0F);
      rchk(4'hC, 32'hFFFF, nb);
      rchk(4'h4, 32'h3F, 44);
      i_host.ram_at(6'd40, 3, 8'hFF);
      rchk(4'h4, 32'h3F, 44);
      rchk(4'h8, 32'h1, 32'h1);
      rchk(4'hC, 32'hFFFF, ((3 - k) << 8) | (nb + k));
    end
    $display("test 2 done");
    for (m = 0; m < 4; m++) begin
      i_host.cmd(8'hF8 | m[1:0]);
      rchk(4'h8, 32'h30, {m[1:0], 4'h0});
      rchk(4'h0, 32'hC, {m[0], m[1], 2'h0});
    end
    $display("test 3 done");
    // bank one never written yet, so shown blank: element off matches backplane
    bus(1'b1, 4'h0, 32'hD);
    frames(2100);
    @(negedge clk);
    check(seg[7:0], {8{bpa}});
    @(posedge clk);
    i_host.ram_at(6'd0, 1, 8'hC1);
    frames(2100);
    @(negedge clk);
    check(seg[7:0], {8{bpa}} ^ 8'h83);
    check({20'h0, seg[43:32]}, {20'h0, {12{bpa}}});
    check({bpb, bpc, bpd}, {3{bpa}});
    @(posedge clk);
    bus(1'b1, 4'h0, 32'h9);
    frames(2100);
    @(negedge clk);
    check(seg[7:0], {8{bpa}} ^ 8'h83);
    @(posedge clk);
    bus(1'b1, 4'h0, 32'h2);
    frames(3000);
    @(negedge clk);
    check({bpc, bpd}, {bpa, bpb});
    @(posedge clk);
    bus(1'b1, 4'h0, 32'h0);
    frames(5000);
    $display("test 4 done");
    conclude;
  end
endmodule
`default_nettype wire
